// ==== design/lsmp_framer.sv ====
// Transport framer, channel routing and serializer power-down for formats 12 to 18.
`timescale 1ns/1ns
// Summary of operation
// - 12-bit decimate-by-4: lane 2k/2k+1 carry I/Q samples k+4j; nibble 15 is tail.
// - 15-bit decimate-by-8 two lanes: lane 0 carries I in octets 0-1, Q in 2-3.
// - 15-bit decimate-by-8 four lanes: lane 0 carries I, lane 1 carries Q.
// - 15-bit decimate-by-16 one lane: A lane 0 carries AI, AQ, BI, BQ.
// - 15-bit decimate-by-16 two lanes: lane 0 carries I then Q per link.
// - 8-bit single channel: A lane x carries sample 2x, B lane x 2x+1.
// - 8-bit dual channel: A lane x carries A sample x, B lane x B sample x.
// - Route selects can feed one converter channel into both down-converters.
// - The unused converter channel powers down when its power-down bit is set.
// - Route selects copy one channel to both links, except in single-channel formats.
// - Sleep pin or mode field powers the whole device down.
// - Lane drivers go off on the third clock edge that sees the sleep pin high (two-flop synchronizer).
// - Mode field other than 0x00 or 0x01 powers down every serializer.
// - Channel power-down bit turns off that converter channel and its lanes.
// - Formats using fewer than sixteen lanes power down the unused serializers.
// - Spare-lane keepalive keeps unused serializers of that link toggling.
// - Two links form in every format except the single-lane one.
module lsmp_framer (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Configuration.
  input wire logic [4:0] lane_format_select_in,
  input wire logic [7:0] cfg_mode_in,
  input wire logic chan_a_route_select_in,
  input wire logic chan_b_route_select_in,
  input wire logic chan_a_powerdown_in,
  input wire logic chan_b_powerdown_in,
  input wire logic link_a_spare_lane_keepalive_in,
  input wire logic link_b_spare_lane_keepalive_in,
  // Sleep pin, asynchronous to clk_in.
  input wire logic device_sleep_pin_in,
  // Sample frame from the down-converters.
  input wire logic samp_valid_in,
  input wire lsmp_pkg::lsmp_smp_t chan_a_inphase_in,
  input wire lsmp_pkg::lsmp_smp_t chan_a_quad_in,
  input wire lsmp_pkg::lsmp_smp_t chan_b_inphase_in,
  input wire lsmp_pkg::lsmp_smp_t chan_b_quad_in,
  // Lane frames and serializer enables.
  output lsmp_pkg::lsmp_lanes_t link_a_lane_out,
  output lsmp_pkg::lsmp_lanes_t link_b_lane_out,
  output logic [7:0] link_a_lane_en_out,
  output logic [7:0] link_b_lane_en_out,
  output logic frame_valid_out,
  // Converter and down-converter control.
  output logic chan_a_adc_en_out,
  output logic chan_b_adc_en_out,
  output logic ddc_a_from_chan_b_out,
  output logic ddc_b_from_chan_a_out
);

  lsmp_pkg::lsmp_state_s s_q;
  lsmp_pkg::lsmp_state_s s_d;

  lsmp_pkg::lsmp_smp_t path_a_i;
  lsmp_pkg::lsmp_smp_t path_a_q;
  lsmp_pkg::lsmp_smp_t path_b_i;
  lsmp_pkg::lsmp_smp_t path_b_q;
  logic single_chan;
  logic all_off;
  logic [7:0] mask_a;
  logic [7:0] mask_b;

  // Lanes used on link A by a format; unknown formats use none.
  function automatic logic [7:0] lane_mask(input logic [4:0] fmt);
    logic [7:0] m;
    m = lsmp_pkg::LSMP_MASK_NONE;
    case (fmt)
      lsmp_pkg::LSMP_FMT_12B_D4_16L,
      lsmp_pkg::LSMP_FMT_8B_SC_16L,
      lsmp_pkg::LSMP_FMT_8B_DC_16L: m = lsmp_pkg::LSMP_MASK_16L;
      lsmp_pkg::LSMP_FMT_15B_D8_4L: m = lsmp_pkg::LSMP_MASK_4L;
      lsmp_pkg::LSMP_FMT_15B_D8_2L,
      lsmp_pkg::LSMP_FMT_15B_D16_1L,
      lsmp_pkg::LSMP_FMT_15B_D16_2L: m = lsmp_pkg::LSMP_MASK_2L;
      default: m = lsmp_pkg::LSMP_MASK_NONE;
    endcase
    return m;
  endfunction : lane_mask

  // Builds one lane frame of one link; odd picks odd samples in the single-channel format.
  function automatic logic [63:0] build_lane(
    input logic [4:0] fmt,
    input logic [2:0] lane,
    input lsmp_pkg::lsmp_smp_t si,
    input lsmp_pkg::lsmp_smp_t sq,
    input logic odd
  );
    logic [63:0] w;
    int idx;
    w = '0;
    idx = 0;
    case (fmt)
      lsmp_pkg::LSMP_FMT_12B_D4_16L: begin
        for (int j = 0; j < lsmp_pkg::LSMP_SMP12_CNT; j++) begin
          idx = int'(lane[2:1]) + lsmp_pkg::LSMP_SMP12_STEP * j;
          w[63 - lsmp_pkg::LSMP_SMP12_W * j -: lsmp_pkg::LSMP_SMP12_W] =
            lane[0] ? sq[idx][11:0] : si[idx][11:0];
        end
        w[3:0] = lsmp_pkg::LSMP_TAIL;
      end
      // Spare lanes held alive by the keepalive carry all-zero frames.
      lsmp_pkg::LSMP_FMT_15B_D8_2L,
      lsmp_pkg::LSMP_FMT_15B_D16_2L: begin
        if (lane == 3'h0) begin
          w[63:32] = {si[0][14:0], lsmp_pkg::LSMP_PAD,
                      sq[0][14:0], lsmp_pkg::LSMP_PAD};
        end
      end
      lsmp_pkg::LSMP_FMT_15B_D8_4L: begin
        if (lane[2:1] == 2'b00) begin
          w[63:48] = lane[0] ? {sq[0][14:0], lsmp_pkg::LSMP_PAD}
                             : {si[0][14:0], lsmp_pkg::LSMP_PAD};
        end
      end
      lsmp_pkg::LSMP_FMT_8B_SC_16L: begin
        idx = 2 * int'(lane) + int'(odd);
        w[63:56] = si[idx][7:0];
      end
      lsmp_pkg::LSMP_FMT_8B_DC_16L: begin
        w[63:56] = si[lane][7:0];
      end
      default: w = '0;
    endcase
    return w;
  endfunction : build_lane

  // Channel routing toward the down-converters and links.
  always_comb begin
    single_chan = (lane_format_select_in == lsmp_pkg::LSMP_FMT_8B_SC_16L);
    path_a_i = chan_a_inphase_in;
    path_a_q = chan_a_quad_in;
    path_b_i = chan_b_inphase_in;
    path_b_q = chan_b_quad_in;
    if (chan_a_route_select_in && !single_chan) begin
      path_a_i = chan_b_inphase_in;
      path_a_q = chan_b_quad_in;
    end
    if (chan_b_route_select_in && !single_chan) begin
      path_b_i = chan_a_inphase_in;
      path_b_q = chan_a_quad_in;
    end
    // The single-channel format splits one stream across both links.
    if (single_chan) begin
      path_b_i = chan_a_inphase_in;
      path_b_q = chan_a_quad_in;
    end
  end

  // Serializer power-down decisions.
  always_comb begin
    all_off = s_q.sleep_sync ||
              (cfg_mode_in != lsmp_pkg::LSMP_CFG_MODE_RUN0 &&
               cfg_mode_in != lsmp_pkg::LSMP_CFG_MODE_RUN1);
    mask_a = lane_mask(lane_format_select_in);
    mask_b = (lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D16_1L) ?
             lsmp_pkg::LSMP_MASK_NONE : mask_a;
    if (link_a_spare_lane_keepalive_in && mask_a != lsmp_pkg::LSMP_MASK_NONE) begin
      mask_a = lsmp_pkg::LSMP_MASK_16L;
    end
    if (link_b_spare_lane_keepalive_in && mask_a != lsmp_pkg::LSMP_MASK_NONE) begin
      mask_b = lsmp_pkg::LSMP_MASK_16L;
    end
  end

  // Next state.
  always_comb begin
    s_d = s_q;
    s_d.sleep_meta = device_sleep_pin_in;
    s_d.sleep_sync = s_q.sleep_meta;
    s_d.a_en = (all_off || chan_a_powerdown_in) ? lsmp_pkg::LSMP_MASK_NONE : mask_a;
    s_d.b_en = (all_off || chan_b_powerdown_in) ? lsmp_pkg::LSMP_MASK_NONE : mask_b;
    s_d.adc_a_en = !(all_off || chan_a_powerdown_in);
    s_d.adc_b_en = !(all_off || chan_b_powerdown_in);
    s_d.ddc_a_from_b = chan_a_route_select_in && !single_chan;
    s_d.ddc_b_from_a = chan_b_route_select_in && !single_chan;
    s_d.valid = samp_valid_in && ((s_d.a_en | s_d.b_en) != lsmp_pkg::LSMP_MASK_NONE);
    if (samp_valid_in) begin
      for (int l = 0; l < 8; l++) begin
        s_d.a_data[l] = s_d.a_en[l] ?
          build_lane(lane_format_select_in, 3'(l), path_a_i, path_a_q, 1'b0) : '0;
        s_d.b_data[l] = s_d.b_en[l] ?
          build_lane(lane_format_select_in, 3'(l), path_b_i, path_b_q, 1'b1) : '0;
      end
      if (lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D16_1L && s_d.a_en[0]) begin
        s_d.a_data[0] = {path_a_i[0][14:0], lsmp_pkg::LSMP_PAD,
                         path_a_q[0][14:0], lsmp_pkg::LSMP_PAD,
                         path_b_i[0][14:0], lsmp_pkg::LSMP_PAD,
                         path_b_q[0][14:0], lsmp_pkg::LSMP_PAD};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= lsmp_pkg::LSMP_RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign link_a_lane_out = s_q.a_data;
  assign link_b_lane_out = s_q.b_data;
  assign link_a_lane_en_out = s_q.a_en;
  assign link_b_lane_en_out = s_q.b_en;
  assign frame_valid_out = s_q.valid;
  assign chan_a_adc_en_out = s_q.adc_a_en;
  assign chan_b_adc_en_out = s_q.adc_b_en;
  assign ddc_a_from_chan_b_out = s_q.ddc_a_from_b;
  assign ddc_b_from_chan_a_out = s_q.ddc_b_from_a;

  // Checks.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic run_a;
  assign run_a = samp_valid_in && !all_off && !chan_a_powerdown_in;

  sequence sleep_held_s;
    device_sleep_pin_in [*3];
  endsequence

  sequence lanes_dark_s;
    (link_a_lane_en_out == 8'h00) && (link_b_lane_en_out == 8'h00) && !chan_a_adc_en_out;
  endsequence

  map_12bit_a: assert property (
    run_a && lane_format_select_in == lsmp_pkg::LSMP_FMT_12B_D4_16L |=>
      link_a_lane_out[3][63:52] == $past(path_a_q[1][11:0]) &&
      link_a_lane_out[3][15:4] == $past(path_a_q[17][11:0]) &&
      link_a_lane_out[3][3:0] == 4'h0)
    else $error("12-bit lane frame mismatch");

  map_d8_two_a: assert property (
    run_a && lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D8_2L |=>
      link_a_lane_out[0][63:32] == {$past(path_a_i[0][14:0]), 1'b0,
                                    $past(path_a_q[0][14:0]), 1'b0})
    else $error("decimate-by-8 two-lane frame mismatch");

  map_d8_four_a: assert property (
    run_a && lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D8_4L |=>
      link_a_lane_out[1][63:48] == {$past(path_a_q[0][14:0]), 1'b0} &&
      link_a_lane_en_out[7:2] == ($past(link_a_spare_lane_keepalive_in) ? 6'h3f : 6'h00))
    else $error("decimate-by-8 four-lane frame mismatch");

  map_single_lane_a: assert property (
    run_a && lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D16_1L |=>
      link_a_lane_out[0][31:16] == {$past(path_b_i[0][14:0]), 1'b0} &&
      link_b_lane_en_out ==
        ($past(link_b_spare_lane_keepalive_in && !chan_b_powerdown_in) ? 8'hff : 8'h00))
    else $error("single-lane frame mismatch");

  map_d16_two_a: assert property (
    run_a && lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D16_2L |=>
      link_a_lane_out[0][47:33] == $past(path_a_q[0][14:0]))
    else $error("decimate-by-16 two-lane frame mismatch");

  map_8bit_sc_a: assert property (
    run_a && !chan_b_powerdown_in &&
    lane_format_select_in == lsmp_pkg::LSMP_FMT_8B_SC_16L |=>
      link_b_lane_out[1][63:56] == $past(chan_a_inphase_in[3][7:0]) &&
      link_a_lane_out[1][63:56] == $past(chan_a_inphase_in[2][7:0]))
    else $error("8-bit single-channel frame mismatch");

  map_8bit_dc_a: assert property (
    run_a && lane_format_select_in == lsmp_pkg::LSMP_FMT_8B_DC_16L |=>
      link_a_lane_out[5][63:56] == $past(path_a_i[5][7:0]))
    else $error("8-bit dual-channel frame mismatch");

  redundant_copy_a: assert property (
    run_a && !chan_b_powerdown_in && chan_b_route_select_in && !chan_a_route_select_in &&
    lane_format_select_in == lsmp_pkg::LSMP_FMT_8B_DC_16L |=>
      link_b_lane_out == link_a_lane_out && ddc_b_from_chan_a_out)
    else $error("redundant link copy mismatch");

  sleep_pin_a: assert property (
    sleep_held_s |=> lanes_dark_s)
    else $error("lanes driven while sleep pin high");

  mode_field_a: assert property (
    cfg_mode_in > 8'h01 |=> lanes_dark_s)
    else $error("lanes driven with power-down mode field");

  chan_pd_a: assert property (
    chan_b_powerdown_in |=> link_b_lane_en_out == 8'h00 && !chan_b_adc_en_out)
    else $error("channel B lanes live while powered down");

  unused_lanes_a: assert property (
    !all_off && !chan_a_powerdown_in &&
    lane_format_select_in == lsmp_pkg::LSMP_FMT_15B_D16_2L |=>
      link_a_lane_en_out == ($past(link_a_spare_lane_keepalive_in) ? 8'hff : 8'h01))
    else $error("unused lane enables wrong");

endmodule : lsmp_framer

// ==== design/lsmp_pkg.sv ====
// Constants and types for the lane sample mapper and power-down controller.
package lsmp_pkg;

  // Lane format codes handled by this framer.
  localparam logic [4:0] LSMP_FMT_12B_D4_16L = 5'h0c;
  localparam logic [4:0] LSMP_FMT_15B_D8_2L = 5'h0d;
  localparam logic [4:0] LSMP_FMT_15B_D8_4L = 5'h0e;
  localparam logic [4:0] LSMP_FMT_15B_D16_1L = 5'h0f;
  localparam logic [4:0] LSMP_FMT_15B_D16_2L = 5'h10;
  localparam logic [4:0] LSMP_FMT_8B_SC_16L = 5'h11;
  localparam logic [4:0] LSMP_FMT_8B_DC_16L = 5'h12;

  // Mode field values that keep the serializers running.
  localparam logic [7:0] LSMP_CFG_MODE_RUN0 = 8'h00;
  localparam logic [7:0] LSMP_CFG_MODE_RUN1 = 8'h01;

  // Lanes in use per link for each format.
  localparam logic [7:0] LSMP_MASK_16L = 8'hff;
  localparam logic [7:0] LSMP_MASK_4L = 8'h03;
  localparam logic [7:0] LSMP_MASK_2L = 8'h01;
  localparam logic [7:0] LSMP_MASK_NONE = 8'h00;

  // Field layout of a lane frame; octet 0 sits in the top bits.
  localparam int LSMP_FRAME_W = 64;
  localparam int LSMP_SMP12_W = 12;
  localparam int LSMP_SMP12_CNT = 5;
  localparam int LSMP_SMP12_STEP = 4;
  localparam logic [3:0] LSMP_TAIL = 4'h0;
  localparam logic LSMP_PAD = 1'b0;

  typedef logic [19:0][15:0] lsmp_smp_t;
  typedef logic [7:0][63:0] lsmp_lanes_t;

  typedef struct packed {
    logic sleep_meta;
    logic sleep_sync;
    lsmp_lanes_t a_data;
    lsmp_lanes_t b_data;
    logic [7:0] a_en;
    logic [7:0] b_en;
    logic valid;
    logic adc_a_en;
    logic adc_b_en;
    logic ddc_a_from_b;
    logic ddc_b_from_a;
  } lsmp_state_s;

  localparam lsmp_state_s LSMP_RESET_STATE = '0;

endpackage : lsmp_pkg

// ==== dv/lsmp_framer_tb.sv ====
// Self-checking bench for the lane sample mapper and power-down controller.
`timescale 1ns/1ns
module lsmp_framer_tb;
  `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %0t %h %h", $time, a, e); end end
  typedef struct packed {
    lsmp_pkg::lsmp_lanes_t a;
    lsmp_pkg::lsmp_lanes_t b;
    logic [15:0] en;
    logic [3:0] c;
    logic [3:0] cm;
  } lsmp_exp_s;
  logic clk_in = 0, rstn_in = 0, sv = 0, sl = 0, ra = 0, rb = 0, pa = 0, pb = 0, ka = 0, kb = 0;
  logic [4:0] fmt = 5'h0c;
  logic [7:0] mode = 8'h00, ea, eb;
  lsmp_pkg::lsmp_smp_t ai = '0, aq = '0, bi = '0, bq = '0;
  lsmp_pkg::lsmp_lanes_t la, lb;
  logic fv, aen, ben, dab, dba;
  logic [15:0] kept;
  int errors = 0, comparisons = 0, npush = 0;
  lsmp_exp_s q[$], me;
  logic [18:0] tbl[10] = '{{5'h0c, 2'b01, 2'b10, 2'b00, 8'h00}, {5'h12, 2'b10, 2'b01, 2'b00, 8'h01},
    {5'h0c, 2'b00, 2'b11, 2'b00, 8'h00}, {5'h12, 2'b00, 2'b00, 2'b00, 8'h02},
    {5'h12, 2'b00, 2'b00, 2'b11, 8'h80}, {5'h11, 2'b00, 2'b00, 2'b00, 8'hff},
    {5'h0e, 2'b00, 2'b00, 2'b11, 8'h00}, {5'h0f, 2'b00, 2'b00, 2'b01, 8'h00},
    {5'h0d, 2'b00, 2'b10, 2'b11, 8'h00}, {5'h10, 2'b11, 2'b00, 2'b10, 8'h01}};
  always #25 clk_in = ~clk_in;
  lsmp_framer u_lsmp_framer (.clk_in(clk_in), .rstn_in(rstn_in), .lane_format_select_in(fmt),
    .cfg_mode_in(mode), .chan_a_route_select_in(ra), .chan_b_route_select_in(rb),
    .chan_a_powerdown_in(pa), .chan_b_powerdown_in(pb), .link_a_spare_lane_keepalive_in(ka),
    .link_b_spare_lane_keepalive_in(kb), .device_sleep_pin_in(sl), .samp_valid_in(sv),
    .chan_a_inphase_in(ai), .chan_a_quad_in(aq), .chan_b_inphase_in(bi), .chan_b_quad_in(bq),
    .link_a_lane_out(la), .link_b_lane_out(lb), .link_a_lane_en_out(ea),
    .link_b_lane_en_out(eb), .frame_valid_out(fv), .chan_a_adc_en_out(aen),
    .chan_b_adc_en_out(ben), .ddc_a_from_chan_b_out(dab), .ddc_b_from_chan_a_out(dba));
  lsmp_rx_model u_lsmp_rx_model (.clk_in(clk_in), .rstn_in(rstn_in), .sleep_in(sl),
    .frame_valid_in(fv), .lane_en_in({ea, eb}), .kept_out(kept));
  task automatic send(input logic [4:0] f, input logic [1:0] r, p, k, input logic [7:0] md);
    lsmp_exp_s e;
    lsmp_pkg::lsmp_smp_t si, sq;
    logic [7:0] m;
    logic [63:0] d;
    @(negedge clk_in);
    for (int i = 0; i < 20; i++) begin
      ai[i] = 16'($urandom);
      aq[i] = 16'($urandom);
      bi[i] = 16'($urandom);
      bq[i] = 16'($urandom);
    end
    {fmt, ra, rb, pa, pb, ka, kb, mode, sv} = {f, r, p, k, md, 1'b1};
    e = '0;
    e.cm = (f == 5'h11) ? 4'hc : 4'hf;
    e.c = {!pa && md < 8'h02 && !sl, !pb && md < 8'h02 && !sl, r};
    for (int l = 0; l < 2; l++) begin
      si = (l == 0 ? ra : !rb) ? bi : ai;
      sq = (l == 0 ? ra : !rb) ? bq : aq;
      m = (f == 5'h0c || f > 5'h10) ? 8'hff : (f == 5'h0e) ? 8'h03 : 8'h01;
      if (f == 5'h0f && l == 1) m = 8'h00;
      if (k[1-l]) m = 8'hff;
      if (p[1-l] || md > 8'h01 || sl) m = 8'h00;
      e.en[15-8*l -: 8] = m;
      for (int x = 0; x < 8; x++) begin
        d = '0;
        case (f)
          5'h0c: for (int j = 0; j < 5; j++)
            d[63-12*j -: 12] = (x % 2 == 1) ? sq[x/2+4*j][11:0] : si[x/2+4*j][11:0];
          5'h0d, 5'h10: if (x == 0) d[63:32] = {si[0][14:0], 1'b0, sq[0][14:0], 1'b0};
          5'h0e: if (x < 2) d[63:48] = {(x == 1) ? sq[0][14:0] : si[0][14:0], 1'b0};
          5'h0f: if (x == 0 && l == 0)
            d = {ai[0][14:0], 1'b0, aq[0][14:0], 1'b0, bi[0][14:0], 1'b0, bq[0][14:0], 1'b0};
          5'h11: d[63:56] = ai[2*x+l][7:0];
          default: d[63:56] = si[x][7:0];
        endcase
        if (!m[x]) d = '0;
        if (l == 0) e.a[x] = d;
        else e.b[x] = d;
      end
    end
    if (|e.en) begin
      q.push_back(e);
      npush++;
    end
  endtask : send
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_in);
      sv = 1'b0;
    end
  endtask : idle
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_in) begin
    #1;
    if (fv === 1'b1) begin
      if (q.size() == 0) `CHK(fv, 1'b0)
      else begin
        me = q.pop_front();
        `CHK(la, me.a)
        `CHK(lb, me.b)
        `CHK({ea, eb}, me.en)
        `CHK({aen, ben, dab, dba} & me.cm, me.c & me.cm)
      end
    end
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hbd68e550));
    repeat (8) @(negedge clk_in);
    rstn_in = 1'b1;
    for (int f = 12; f <= 18; f++)
      for (int r = 0; r < 4; r++) send(5'(f), (f == 15) ? 2'b00 : 2'(r), 2'b00, 2'b00, 8'h00);
    foreach (tbl[i]) send(tbl[i][18:14], tbl[i][13:12], tbl[i][11:10], tbl[i][9:8], tbl[i][7:0]);
    idle(1);
    sl = 1'b1;
    idle(4);
    `CHK({ea, eb, aen, ben}, 18'h0)
    send(5'h12, 2'b00, 2'b00, 2'b11, 8'h00);
    idle(1);
    sl = 1'b0;
    idle(4);
    repeat (4) send(5'h12, 2'b00, 2'b00, 2'b00, 8'h00);
    idle(3);
    `CHK(q.size(), 0)
    `CHK(kept, 16'(npush - 2))
    report_and_stop();
  end
endmodule : lsmp_framer_tb

// ==== dv/lsmp_rx_model.sv ====
// Receiver model that drops stale frames after a wake-up.
`timescale 1ns/1ns
module lsmp_rx_model #(
  parameter int FLUSH_FRAMES = 2
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Lane traffic.
  input wire logic sleep_in,
  input wire logic frame_valid_in,
  input wire logic [15:0] lane_en_in,
  // Frames taken.
  output logic [15:0] kept_out
);
  logic [7:0] drop_q;
  logic sleep_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      drop_q <= 8'h00;
      sleep_q <= 1'b0;
      kept_out <= 16'h0000;
    end else begin
      sleep_q <= sleep_in;
      // Pipeline and filters hold stale data on wake-up, so those frames go.
      if (sleep_q && !sleep_in) begin
        drop_q <= 8'(FLUSH_FRAMES);
      end else if (frame_valid_in && |lane_en_in) begin
        if (drop_q != 8'h00) drop_q <= drop_q - 8'h01;
        else kept_out <= kept_out + 16'h0001;
      end
    end
  end
endmodule : lsmp_rx_model
